//--- logic/mmsc_pkg.sv
// package for the motor mode and standby controller
// assumes one 125 MHz clock and an AXI4-Lite register port
package mmsc_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] REG_CTRL_ADDR = 8'h00;
	localparam logic [7:0] REG_STAT_ADDR = 8'h04;
	// register 14 keeps its number as an index; the byte address is four times it
	localparam int REG_CFG14_IDX = 14;
	localparam logic [7:0] REG_CFG14_ADDR = 8'(REG_CFG14_IDX * 4);
	localparam int CFG14_SEL_BIT = 7;
	localparam int CTRL_BLOCK_A_BIT = 0;
	localparam int CTRL_BLOCK_B_BIT = 1;
	localparam int CTRL_BLOCK_C_BIT = 2;
	localparam int CTRL_ERRCLR_BIT = 3;
	localparam logic [7:0] CFG14_RESET = 8'h00;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 125;
	localparam int STANDBY_INPUT_PIN_HOLD_MS = 100;
	localparam int STANDBY_INPUT_PIN_HOLD_CYC = STANDBY_INPUT_PIN_HOLD_MS * 1000 * CLK_MHZ;
	localparam int RESTART_MS = 1000;
	localparam int RESTART_CYC = RESTART_MS * 1000 * CLK_MHZ;
	localparam int BRAKE_MS = 1000;
	localparam int BRAKE_CYC = BRAKE_MS * 1000 * CLK_MHZ;
	localparam int LOAD_WORDS = 32;
	typedef enum logic [2:0] {
		ST_STANDBY = 3'b000,
		ST_LOAD = 3'b001,
		ST_BRAKE = 3'b010,
		ST_IDLE = 3'b011,
		ST_START = 3'b100,
		ST_RUN = 3'b101,
		ST_ERROR = 3'b110
	} mmsc_state_type;
	typedef struct packed {
		logic drive_en;
		logic brake_en;
		logic start_en;
		logic outputs_off;
	} mmsc_drive_type;
endpackage : mmsc_pkg

//--- logic/mmsc_top.sv
// operating mode controller: power-up load, brake, idle, run, error, standby
// assumes pins are asynchronous and the startup block on aclk answers start_done
//
// How it works
// [R01] after reset without standby: load store, run brake, then idle
// [R02] speed command starts motor via startup; withdrawal stops driving
// [R03] a fault in start or run enters error mode; restart after restart time
// [R04] in error mode with speed at stop, go to idle
// [R05] standby turns all outputs off and clears latched errors
// [R06] select 0: standby whenever standby pin is low
// [R07] select 1: standby needs pin low and speed command zero
// [R08] select 1: any blocking setting set forbids standby
// [R09] host holds standby condition at least 100 ms to leave normal operation
// [R10] idle turns off all power transistors; speed command goes to startup
// [R11] leaving standby repeats load, brake, then idle
`timescale 1ns/1ns
module mmsc_top
	import mmsc_pkg::*;
#(
	parameter int STANDBY_INPUT_PIN_HOLD = mmsc_pkg::STANDBY_INPUT_PIN_HOLD_CYC,
	parameter int RESTART = mmsc_pkg::RESTART_CYC,
	parameter int BRAKE = mmsc_pkg::BRAKE_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic standby_input_pin,
	input wire logic speed_cmd_pin,
	input wire logic fault_in,
	input wire logic start_done,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic parameter_store_rd,
	output mmsc_pkg::mmsc_drive_type drive_r,
	output logic error_flag_r
);
	import mmsc_pkg::*;

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
		addr_hit = (a[7:2] == r[7:2]);
	endfunction : addr_hit

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0] standby_input_pin_sync_r, spd_sync_r, flt_sync_r;
	logic [1:0] standby_input_pin_sync_nxt, spd_sync_nxt, flt_sync_nxt;
	logic standby_input_pin_low, spd_on, fault;
	always_comb begin
		standby_input_pin_sync_nxt = {standby_input_pin_sync_r[0], standby_input_pin};
		spd_sync_nxt = {spd_sync_r[0], speed_cmd_pin};
		flt_sync_nxt = {flt_sync_r[0], fault_in};
		standby_input_pin_low = ~standby_input_pin_sync_r[1];
		spd_on = spd_sync_r[1];
		fault = flt_sync_r[1];
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			standby_input_pin_sync_r <= 2'h3;
			spd_sync_r <= 2'h0;
			flt_sync_r <= 2'h0;
		end else begin
			standby_input_pin_sync_r <= standby_input_pin_sync_nxt;
			spd_sync_r <= spd_sync_nxt;
			flt_sync_r <= flt_sync_nxt;
		end
	end

	// ****************************************
	// registers over AXI4-Lite
	// ****************************************
	logic [7:0] cfg14_r, cfg14_nxt;
	logic [2:0] ctrl_r, ctrl_nxt;
	logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [7:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic err_clear_req;
	mmsc_state_type state_r, state_nxt;

	always_comb begin
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt = w_hold_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		cfg14_nxt = cfg14_r;
		ctrl_nxt = ctrl_r;
		err_clear_req = 1'b0;
		if (s_axi_awvalid && !aw_hold_r && !bvalid_r) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_hold_r && !bvalid_r) begin
			w_hold_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (aw_hold_r && w_hold_r) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = RESP_OKAY;
			if (addr_hit(awaddr_r, REG_CFG14_ADDR)) begin
				if (wstrb_r[0])
					cfg14_nxt = wdata_r[7:0];
			end else if (addr_hit(awaddr_r, REG_CTRL_ADDR)) begin
				if (wstrb_r[0]) begin
					ctrl_nxt = wdata_r[2:0];
					err_clear_req = wdata_r[CTRL_ERRCLR_BIT];
				end
			end else if (!addr_hit(awaddr_r, REG_STAT_ADDR)) begin
				bresp_nxt = RESP_SLVERR;
			end
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
		if (s_axi_arvalid && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = 32'h0;
			if (addr_hit(s_axi_araddr, REG_CFG14_ADDR))
				rdata_nxt = {24'h0, cfg14_r};
			else if (addr_hit(s_axi_araddr, REG_CTRL_ADDR))
				rdata_nxt = {29'h0, ctrl_r};
			else if (addr_hit(s_axi_araddr, REG_STAT_ADDR))
				rdata_nxt = {26'h0, error_flag_r, standby_input_pin_low, spd_on, state_r};
			else
				rresp_nxt = RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0;
			cfg14_r <= CFG14_RESET;
			ctrl_r <= CTRL_RESET;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_arready <= 1'b1;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			cfg14_r <= cfg14_nxt;
			ctrl_r <= ctrl_nxt;
			// readies from flops: same value as the old decode, no path back from the valids
			s_axi_awready <= !aw_hold_nxt && !bvalid_nxt;
			s_axi_wready <= !w_hold_nxt && !bvalid_nxt;
			s_axi_arready <= !rvalid_nxt;
		end
	end

	// ****************************************
	// standby qualification
	// ****************************************
	logic standby_input_pin_want, blocked;
	logic [31:0] hold_cnt_r, hold_cnt_nxt;
	logic standby_input_pin_go;
	always_comb begin
		blocked = ctrl_r[CTRL_BLOCK_A_BIT] | ctrl_r[CTRL_BLOCK_B_BIT] | ctrl_r[CTRL_BLOCK_C_BIT];
		if (!cfg14_r[CFG14_SEL_BIT])
			standby_input_pin_want = standby_input_pin_low; // R06
		else
			standby_input_pin_want = standby_input_pin_low && !spd_on && !blocked; // R07 R08
		hold_cnt_nxt = standby_input_pin_want ? hold_cnt_r : 32'h0;
		if (standby_input_pin_want && hold_cnt_r < 32'(STANDBY_INPUT_PIN_HOLD))
			hold_cnt_nxt = hold_cnt_r + 32'h1;
		// the 100 ms filter keeps glitches on the pin from dropping the motor
		standby_input_pin_go = standby_input_pin_want && (hold_cnt_r >= 32'(STANDBY_INPUT_PIN_HOLD)); // R09
	end

	// ****************************************
	// mode sequencer
	// ****************************************
	logic [31:0] tmr_r, tmr_nxt;
	logic err_lat_nxt;
	mmsc_drive_type drive_nxt;
	always_comb begin
		state_nxt = state_r;
		tmr_nxt = tmr_r + 32'h1;
		err_lat_nxt = error_flag_r;
		case (state_r)
			ST_STANDBY: begin
				err_lat_nxt = 1'b0; // R05
				tmr_nxt = 32'h0;
				if (!standby_input_pin_want) // R11
					state_nxt = ST_LOAD;
			end
			ST_LOAD: begin
				if (tmr_r == 32'(LOAD_WORDS - 1)) begin // R01
					state_nxt = ST_BRAKE;
					tmr_nxt = 32'h0;
				end
			end
			ST_BRAKE: begin
				if (tmr_r >= 32'(BRAKE - 1)) begin // R01
					state_nxt = ST_IDLE;
					tmr_nxt = 32'h0;
				end
			end
			ST_IDLE: begin
				if (spd_on) begin // R10
					state_nxt = ST_START;
					tmr_nxt = 32'h0;
				end
			end
			ST_START: begin
				if (!spd_on)
					state_nxt = ST_IDLE; // R02
				else if (start_done)
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (!spd_on)
					state_nxt = ST_IDLE; // R02
			end
			ST_ERROR: begin
				if (!spd_on)
					state_nxt = ST_IDLE; // R04
				else if (tmr_r >= 32'(RESTART - 1)) begin // R03
					state_nxt = ST_START;
					tmr_nxt = 32'h0;
				end
			end
			default: state_nxt = ST_STANDBY;
		endcase
		if (fault && (state_r == ST_START || state_r == ST_RUN)) begin
			state_nxt = ST_ERROR; // R03
			tmr_nxt = 32'h0;
		end
		// a fault in the same cycle as a software clear keeps the flag
		if (err_clear_req && !fault)
			err_lat_nxt = 1'b0;
		if (fault && state_r != ST_STANDBY)
			err_lat_nxt = 1'b1;
		if (state_r != ST_STANDBY && standby_input_pin_go) begin
			state_nxt = ST_STANDBY;
			err_lat_nxt = 1'b0; // R05
		end
		drive_nxt.drive_en = (state_nxt == ST_RUN);
		drive_nxt.start_en = (state_nxt == ST_START);
		drive_nxt.brake_en = (state_nxt == ST_BRAKE);
		drive_nxt.outputs_off = (state_nxt == ST_STANDBY) || (state_nxt == ST_IDLE); // R05 R10
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_LOAD; // R01
			tmr_r <= 32'h0;
			error_flag_r <= 1'b0;
			drive_r <= '{drive_en: 1'b0, brake_en: 1'b0, start_en: 1'b0, outputs_off: 1'b1};
			hold_cnt_r <= 32'h0;
			parameter_store_rd <= 1'b1;
		end else begin
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
			error_flag_r <= err_lat_nxt;
			drive_r <= drive_nxt;
			hold_cnt_r <= hold_cnt_nxt;
			parameter_store_rd <= (state_nxt == ST_LOAD); // R01
		end
	end
endmodule : mmsc_top

//--- bench/mmsc_assertions.sv
// port checker for mmsc_top
// assumes a bind from the bench top
`timescale 1ns/1ns
module mmsc_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic parameter_store_rd,
	input wire mmsc_pkg::mmsc_drive_type drive_r,
	input wire logic error_flag_r
);
	import mmsc_pkg::*;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_load_first: assert property ($rose(aresetn) |-> ##[0:2] parameter_store_rd)
		else $error("no load");
	a_load_quiet: assert property (parameter_store_rd |-> !drive_r.drive_en)
		else $error("drive in load");
	a_load_brake: assert property ($fell(parameter_store_rd) |-> ##[0:2] drive_r.brake_en)
		else $error("no brake");
	a_drive_sole: assert property (drive_r.drive_en |-> !drive_r.outputs_off && !drive_r.brake_en)
		else $error("drive overlap");
	a_err_stop: assert property ($rose(error_flag_r) |-> ##[0:2] !drive_r.drive_en)
		else $error("drive in error");
	a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid stuck");
	a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid stuck");
	a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("ar taken");
endmodule : mmsc_assertions

//--- bench/mmsc_host_model.sv
// host model driving the standby and speed pins
// assumes requests from the bench on aclk
`timescale 1ns/1ns
module mmsc_host_model #(
	parameter int HOLD = 60
) (
	input wire logic aclk,
	input wire logic standby_input_pin_req,
	input wire logic spd_req,
	output logic standby_input_pin,
	output logic speed_cmd_pin
);
	int cnt_r = 0;
	initial standby_input_pin = 1'b1;
	initial speed_cmd_pin = 1'b0;
	always @(posedge aclk) begin
		speed_cmd_pin <= spd_req;
		cnt_r <= standby_input_pin ? 0 : cnt_r + 1;
		if (standby_input_pin_req)
			standby_input_pin <= 1'b0;
		else if (cnt_r >= HOLD)
			standby_input_pin <= 1'b1;
	end
endmodule : mmsc_host_model

//--- bench/mmsc_top_tb.sv
// bench for mmsc_top: mode flow, standby choice, register port
// assumes package, design, host model and checker compiled first
`timescale 1ns/1ns
module mmsc_top_tb;
	import mmsc_pkg::*;
	logic aclk, aresetn = 1'b0, fault_in = 1'b0, start_done = 1'b0, standby_input_pin_req = 1'b0, spd_req = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	// answers are always accepted at once
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic standby_input_pin, speed_cmd_pin, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, parameter_store_rd, error_flag_r;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	mmsc_drive_type drive_r;
	int num_errors = 0;
	int n_tests = 0;
	mmsc_host_model #(.HOLD(60)) host (.*);
	mmsc_top #(.STANDBY_INPUT_PIN_HOLD(50), .RESTART(40), .BRAKE(20)) dut (.*);
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task end_sim;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task tmo;
		num_errors++;
		$display("mismatch %0t timeout", $time);
		end_sim;
	endtask : tmo
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		if (i == 50)
			tmo;
		chk(s_axi_bresp, RESP_OKAY, "bresp");
	endtask : wr
	task rd(input logic [7:0] a);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		if (i == 50)
			tmo;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd
	task wst(input mmsc_state_type s);
		int i;
		for (i = 0; i < 300; i++) begin
			rd(REG_STAT_ADDR);
			if (d[2:0] === s)
				break;
		end
		if (i == 300)
			tmo;
		chk(d[2:0], s, "state");
	endtask : wst
	// ****************************************
	// scenarios
	// ****************************************
	task t_power;
		repeat (2) @(posedge aclk);
		chk(parameter_store_rd, 1'b1, "load");
		wst(ST_IDLE);
		chk(drive_r, 4'h1, "idle drive");
		rd(REG_CFG14_ADDR);
		chk(d, CFG14_RESET, "cfg14 reset");
		rd(8'h10);
		chk(d, 32'h0, "unmapped data");
		chk(r, RESP_SLVERR, "unmapped resp");
		$display("test power done");
	endtask : t_power
	task t_run;
		spd_req <= 1'b1;
		wst(ST_START);
		chk(drive_r, 4'h2, "start drive");
		start_done <= 1'b1;
		wst(ST_RUN);
		chk(drive_r.drive_en, 1'b1, "run drive");
		spd_req <= 1'b0;
		wst(ST_IDLE);
		chk(drive_r, 4'h1, "stop drive");
		$display("test run done");
	endtask : t_run
	task t_error;
		spd_req <= 1'b1;
		wst(ST_RUN);
		fault_in <= 1'b1;
		wst(ST_ERROR);
		chk(error_flag_r, 1'b1, "flag set");
		fault_in <= 1'b0;
		wst(ST_RUN);
		fault_in <= 1'b1;
		wst(ST_ERROR);
		fault_in <= 1'b0;
		spd_req <= 1'b0;
		wst(ST_IDLE);
		wr(REG_CTRL_ADDR, 32'h8);
		chk(error_flag_r, 1'b0, "soft clear");
		rd(REG_CTRL_ADDR);
		chk(d, 32'h0, "clear bit reads 0");
		$display("test error done");
	endtask : t_error
	task t_stby0;
		spd_req <= 1'b1;
		wst(ST_RUN);
		// latch an error first so the standby clear has something to clear
		fault_in <= 1'b1;
		wst(ST_ERROR);
		chk(error_flag_r, 1'b1, "flag before standby");
		fault_in <= 1'b0;
		standby_input_pin_req <= 1'b1;
		wst(ST_STANDBY);
		chk(error_flag_r, 1'b0, "flag cleared");
		chk(drive_r, 4'h1, "released");
		standby_input_pin_req <= 1'b0;
		spd_req <= 1'b0;
		wst(ST_LOAD);
		wst(ST_IDLE);
		$display("test standby pin done");
	endtask : t_stby0
	task t_stby1;
		int b;
		wr(REG_CFG14_ADDR, 32'h80);
		rd(REG_CFG14_ADDR);
		chk(d, 32'h80, "cfg14");
		spd_req <= 1'b1;
		wst(ST_RUN);
		standby_input_pin_req <= 1'b1;
		repeat (150) @(posedge aclk);
		rd(REG_STAT_ADDR);
		chk(d[2:0], ST_RUN, "no standby");
		spd_req <= 1'b0;
		wst(ST_STANDBY);
		standby_input_pin_req <= 1'b0;
		wst(ST_IDLE);
		for (b = 0; b < 3; b++) begin
			wr(REG_CTRL_ADDR, 32'h1 << b);
			rd(REG_CTRL_ADDR);
			chk(d, 32'h1 << b, "ctrl");
			standby_input_pin_req <= 1'b1;
			repeat (150) @(posedge aclk);
			rd(REG_STAT_ADDR);
			chk(d[2:0], ST_IDLE, "blocked");
			standby_input_pin_req <= 1'b0;
		end
		wr(REG_CTRL_ADDR, 32'h0);
		$display("test standby select done");
	endtask : t_stby1
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_power;
		t_run;
		t_error;
		t_stby0;
		t_stby1;
		end_sim;
	end
endmodule : mmsc_top_tb
bind mmsc_top mmsc_assertions chk_i (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.parameter_store_rd(parameter_store_rd),
	.drive_r(drive_r),
	.error_flag_r(error_flag_r)
);
